// ---- bench/nibble_cpu_data_move_alu_ops_test.sv ----
// Bench for the nibble execute unit against a reference model
`timescale 1ns/1ns
`default_nettype none
module nibble_cpu_data_move_alu_ops_test;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic instr_valid = 1'b0;
   logic [9:0] instr = 10'h000;
   logic [2:0] stack_ptr = 3'h0;
   wire logic [3:0] ram_rdata, acc_r, b_r, x_r, y_r, ram_wdata_r;
   wire logic [9:0] rom_rdata, ram_waddr_r;
   wire logic [7:0] e_r;
   wire logic [2:0] d_r;
   wire logic [1:0] z_r;
   wire logic [12:0] rom_addr_r;
   wire logic instr_ready_r, carry_flag_r, skip_r, ram_we_r, stack_push_r, stack_pop_r;
   logic [3:0] mem [0:1023];
   logic [3:0] mm [0:1023];
   logic [3:0] ma, mb, mx, my, ewd;
   logic [7:0] me;
   logic [2:0] md;
   logic [1:0] mz, pend;
   logic [12:0] mra;
   logic mc, ms, ewe;
   logic [9:0] ewa, prev, rw;
   logic [31:0] seed = 32'd86567;
   int n_mismatch = 0;
   int checks = 0;
   int cyc = 0;
   int k;
   // Opcode bases grouped by operand mask: none, 2 bits, 4 bits, page, x/y
   logic [9:0] tbl [0:36] = '{10'h01e, 10'h00e, 10'h01f, 10'h00c, 10'h01a, 10'h02a, 10'h029,
      10'h051, 10'h053, 10'h052, 10'h050, 10'h013, 10'h017, 10'h00a, 10'h00b, 10'h018, 10'h019,
      10'h007, 10'h006, 10'h02f, 10'h01c, 10'h01d, 10'h026, 10'h025, 10'h048, 10'h05c, 10'h04c,
      10'h020, 10'h2b0, 10'h2c0, 10'h2d0, 10'h2e0, 10'h2f0, 10'h070, 10'h060, 10'h080, 10'h300};
   logic [9:0] dir [0:15] = '{10'h3f5, 10'h312, 10'h3aa, 10'h07a, 10'h073, 10'h30f, 10'h013,
      10'h01e, 10'h017, 10'h00e, 10'h2b3, 10'h2c3, 10'h085, 10'h086, 10'h06f, 10'h029};

   nibble_exec DUT
   (
      .clk, .srst, .instr_valid, .instr, .ram_rdata, .stack_ptr, .rom_rdata, .instr_ready_r,
      .acc_r, .b_r, .e_r, .d_r, .x_r, .y_r, .z_r, .carry_flag_r, .skip_r, .ram_we_r,
      .ram_waddr_r, .ram_wdata_r, .rom_addr_r, .stack_push_r, .stack_pop_r
   );

   function automatic logic [7:0] romf(input logic [12:0] a);
      romf = a[7:0] ^ {a[12:7], 2'h3};
   endfunction

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction

   // Outside RAM with a registered write port, and a ROM pattern
   assign ram_rdata = mem[{z_r, x_r, y_r}];
   assign rom_rdata = {2'h0, romf(rom_addr_r)};
   always @(posedge clk)
      if (ram_we_r)
         mem[ram_waddr_r] <= ram_wdata_r;
   always #10 clk = ~clk;

   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      begin
         checks++;
         if (g !== e)
         begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
         end
      end
   endtask

   task automatic cmp_all;
      begin
         cmp("regs", {ma, mb, me, md, mx, my, mz, mc},
            {acc_r, b_r, e_r, d_r, x_r, y_r, z_r, carry_flag_r});
         cmp("skip", ms, skip_r);
         cmp("rom addr", mra, rom_addr_r);
         cmp("ram write", {ewe, ewe ? {ewa, ewd} : 14'h0},
            {ram_we_r, ram_we_r ? {ram_waddr_r, ram_wdata_r} : 14'h0});
      end
   endtask

   task automatic wr(input logic [9:0] a, input logic [3:0] d);
      begin
         mm[a] = d;
         {ewe, ewa, ewd} = {1'b1, a, d};
      end
   endtask

   // Reference model of one taken word
   task automatic exec(input logic [9:0] w);
      logic [9:0] a;
      logic [3:0] m, j;
      begin
         a = {mz, mx, my};
         m = mm[a];
         j = w[3:0];
         ewe = 1'b0;
         if (pend == 2'd1)
            {ms, pend} = {ma == j, 2'b00};
         else if (ms || pend == 2'd2 || w[9:8] == 2'b11 && prev[9:8] == 2'b11
            || w[9:4] == 6'h07 && prev[9:4] == 6'h07)
            {ms, pend} = {1'b0, (w == 10'h025 && pend == 2'd0) ? 2'd2 : 2'd0};
         else
         begin
            ms = 1'b0;
            if (w[9:4] == 6'h2b || w[9:4] == 6'h2d || w[9:5] == 5'h17)
               wr(a, ma);
            if (w[9:4] == 6'h2b || w[9:6] == 4'hb)
               mx = mx ^ j;
            casez (w)
               10'h01e: ma = mb;
               10'h00e: mb = ma;
               10'h01f: ma = my;
               10'h00c: my = ma;
               10'h052: ma = mx;
               10'h01a: me = {mb, ma};
               10'h02a: {mb, ma} = me;
               10'h029: md = ma[2:0];
               10'h051: ma = {1'b0, md};
               10'h053: ma = {2'b00, mz};
               10'h050: ma = {1'b0, stack_ptr};
               10'b11????????: {mx, my} = w[7:0];
               10'b00010010??: mz = w[1:0];
               10'h013: {my, ms} = {my + 4'h1, my == 4'hf};
               10'h017: {my, ms} = {my - 4'h1, my == 4'h0};
               10'h2c?, 10'h2d?: ma = m;
               10'h2f?: {ma, my, ms} = {m, my - 4'h1, my == 4'h0};
               10'h2e?: {ma, my, ms} = {m, my + 4'h1, my == 4'hf};
               10'h07?: ma = j;
               10'b0010??????:
               begin
                  mra = {w[5:0], md, ma};
                  {mb, ma} = romf(mra);
               end
               10'h00a: ma = ma + m;
               10'h00b: {mc, ma} = ma + m + mc;
               10'h06?: {ms, ma} = ({1'b0, ma} + {1'b0, j}) ^ 5'h10;
               10'h018: ma = ma & m;
               10'h019: ma = ma | m;
               10'h007: mc = 1'b1;
               10'h006: mc = 1'b0;
               10'h02f: ms = !mc;
               10'h01c: ma = ~ma;
               10'h01d: {ma, mc} = {mc, ma};
               10'b00010111??: wr(a, m | (4'h1 << w[1:0]));
               10'b00010011??: wr(a, m & ~(4'h1 << w[1:0]));
               10'b00001000??: ms = !m[w[1:0]];
               10'h026: ms = ma == m;
               10'h025: pend = 2'd1;
               default: ;
            endcase
         end
         prev = w;
      end
   endtask

   // Check the last result, then offer the next word at the falling edge
   task automatic issue(input logic [9:0] w);
      begin
         @(negedge clk);
         while (instr_ready_r !== 1'b1)
            @(negedge clk);
         cmp_all;
         seed = xs(seed);
         stack_ptr = seed[6:4];
         instr_valid = 1'b1;
         instr = w;
         exec(w);
      end
   endtask

   task automatic tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", checks, n_mismatch);
         if (n_mismatch == 0 && checks > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask

   // Cycle ceiling against a hang
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         tally_and_finish;
      end
   end

   initial
   begin
      {ma, mb, mx, my, me, md, mz, mc, ms, ewe, pend, prev, mra} = '0;
      for (int i = 0; i < 1024; i++)
      begin
         seed = xs(seed);
         mem[i] = seed[3:0];
         mm[i] = seed[3:0];
      end
      repeat (10) @(negedge clk);
      srst = 1'b0;
      foreach (dir[i])
         issue(dir[i]);
      // Random stream of legal words, compare pairs followed by an increment
      for (int i = 0; i < 1500; i++)
      begin
         seed = xs(seed);
         k = seed[15:8] % 37;
         rw = tbl[k] | (seed[31:22] & (k < 24 ? 10'h000 : k < 28 ? 10'h003 : k < 35 ? 10'h00f
            : k == 35 ? 10'h03f : 10'h0ff));
         issue(rw);
         if (rw == 10'h025)
         begin
            issue(10'h070 | {6'h00, seed[3:0]});
            issue(10'h013);
         end
      end
      issue(10'h013);
      @(negedge clk);
      instr_valid = 1'b0;
      cmp_all;
      tally_and_finish;
   end
endmodule // nibble_cpu_data_move_alu_ops_test
`default_nettype wire

// ---- bench/nibble_exec_monitor.sv ----
// Port checker for the nibble execute unit
`timescale 1ns/1ns
`default_nettype none
module nibble_exec_monitor
(
   input wire logic clk,
   input wire logic srst,
   input wire logic instr_valid,
   input wire logic [9:0] instr,
   input wire logic instr_ready_r,
   input wire logic [3:0] acc_r,
   input wire logic [2:0] d_r,
   input wire logic [3:0] x_r,
   input wire logic [3:0] y_r,
   input wire logic [1:0] z_r,
   input wire logic skip_r,
   input wire logic ram_we_r,
   input wire logic [9:0] ram_waddr_r,
   input wire logic [3:0] ram_wdata_r,
   input wire logic stack_push_r,
   input wire logic stack_pop_r
);
   logic [9:0] last_w_r;
   wire logic take = instr_valid && instr_ready_r;
   wire logic go = take && !skip_r && last_w_r != 10'h025;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // Last word taken, so a compare pair or a load chain is not mistaken for a lone word
   always @(posedge clk)
   begin
      if (srst)
         last_w_r <= 10'h000;
      else if (take)
         last_w_r <= instr;
   end

   property p_lookup_seq;
      go && instr[9:6] == 4'b0010 |=> stack_push_r && !instr_ready_r
         ##1 !instr_ready_r && !stack_push_r ##1 instr_ready_r && stack_pop_r;
   endproperty
   a_lookup_seq: assert property (p_lookup_seq)
      else $error("lookup push, wait or pop out of step");

   property p_ready_gap;
      $fell(instr_ready_r) |=> !instr_ready_r ##1 instr_ready_r;
   endproperty
   a_ready_gap: assert property (p_ready_gap)
      else $error("ready low for other than two cycles");

   property p_store;
      go && instr[9:4] == 6'h2b |=> ram_we_r && ram_wdata_r == $past(acc_r)
         && ram_waddr_r == {$past(z_r), $past(x_r), $past(y_r)}
         && x_r == ($past(x_r) ^ last_w_r[3:0]);
   endproperty
   a_store: assert property (p_store)
      else $error("store write or pointer update wrong");

   property p_inc_y;
      go && instr == 10'h013 |=> y_r == $past(y_r) + 4'h1 && skip_r == (y_r == 4'h0);
   endproperty
   a_inc_y: assert property (p_inc_y)
      else $error("increment of y or its skip wrong");

   property p_dec_y;
      go && instr == 10'h017 |=> y_r == $past(y_r) - 4'h1 && skip_r == (y_r == 4'hf);
   endproperty
   a_dec_y: assert property (p_dec_y)
      else $error("decrement of y or its skip wrong");

   property p_suppress;
      take && skip_r |=> !skip_r && !ram_we_r && !stack_push_r && $stable(acc_r)
         && $stable(x_r) && $stable(y_r);
   endproperty
   a_suppress: assert property (p_suppress)
      else $error("skipped word changed state");

   property p_xy_chain;
      take && instr[9:8] == 2'b11 && last_w_r[9:8] == 2'b11 |=> $stable(x_r) && $stable(y_r);
   endproperty
   a_xy_chain: assert property (p_xy_chain)
      else $error("chained x/y load was executed");

   property p_page;
      go && instr == 10'h029 |=> {1'b0, d_r} == ($past(acc_r) & 4'h7) && $stable(acc_r);
   endproperty
   a_page: assert property (p_page)
      else $error("page register load wrong");
endmodule // nibble_exec_monitor

bind nibble_exec nibble_exec_monitor u_mon (.clk, .srst, .instr_valid, .instr, .instr_ready_r,
   .acc_r, .d_r, .x_r, .y_r, .z_r, .skip_r, .ram_we_r, .ram_waddr_r, .ram_wdata_r,
   .stack_push_r, .stack_pop_r);
`default_nettype wire

// ---- hdl/nibble_add.v ----
// Four-bit adder with carry in and carry out
`timescale 1ns/1ns
`default_nettype none

module nibble_add
(
   input wire [3:0] op_a,
   input wire [3:0] op_b,
   input wire cin,
   output wire [3:0] sum,
   output wire cout
);

   wire [4:0] full;

   // Widen both operands so the carry is kept
   assign full = {1'b0, op_a} + {1'b0, op_b} + {4'h0, cin};
   assign sum = full[3:0];
   assign cout = full[4];

endmodule // nibble_add

`default_nettype wire

// ---- hdl/nibble_exec.v ----
// Execute unit for data move, RAM pointer, arithmetic, bit and compare instructions
`timescale 1ns/1ns
`default_nettype none
`include "nibble_exec_map.vh"

module nibble_exec
(
   input wire clk,
   input wire srst,
   input wire instr_valid,
   input wire [9:0] instr,
   input wire [3:0] ram_rdata,
   input wire [2:0] stack_ptr,
   input wire [9:0] rom_rdata,
   output reg instr_ready_r,
   output reg [3:0] acc_r,
   output reg [3:0] b_r,
   output reg [7:0] e_r,
   output reg [2:0] d_r,
   output reg [3:0] x_r,
   output reg [3:0] y_r,
   output reg [1:0] z_r,
   output reg carry_flag_r,
   output reg skip_r,
   output reg ram_we_r,
   output reg [9:0] ram_waddr_r,
   output reg [3:0] ram_wdata_r,
   output reg [12:0] rom_addr_r,
   output reg stack_push_r,
   output reg stack_pop_r
);

   localparam [2:0] ST_IDLE = 3'b001, ST_FETCH = 3'b010, ST_LOAD = 3'b100;

   reg [2:0] st_r, st_nxt, d_nxt;
   reg prev_lxy_r, prev_lxy_nxt, prev_la_r, prev_la_nxt, sea_pend_r, sea_pend_nxt;
   reg sea_void_r, sea_void_nxt, instr_ready_nxt, carry_nxt, skip_nxt;
   reg ram_we_nxt, push_nxt, pop_nxt;
   reg [3:0] acc_nxt, b_nxt, x_nxt, y_nxt, ram_wdata_nxt;
   reg [7:0] e_nxt;
   reg [1:0] z_nxt;
   reg [9:0] ram_waddr_nxt;
   reg [12:0] rom_addr_nxt;

   wire take, is_lxy, is_la, is_add_imm, chain_skip, add_ci, add_co;
   wire [9:0] ptr_now;
   wire [3:0] mem, imm, y_up, y_dn, add_b, add_sum;

   // One-hot mask for the bit field of the bit instructions
   function [3:0] bit_mask;
      input [1:0] sel;
      begin
         bit_mask = 4'h1 << sel;
      end
   endfunction

   // Request handshake and operand fields
   assign take = instr_valid & instr_ready_r;
   assign ptr_now = {z_r, x_r, y_r};
   assign imm = instr[`IMM_HI:`IMM_LO];
   assign y_up = y_r + 4'h1;
   assign y_dn = y_r - 4'h1;

   // Bypass a RAM write still in flight to the same address
   assign mem = (ram_we_r && (ram_waddr_r == ptr_now)) ? ram_wdata_r : ram_rdata;

   // Opcode classes needed outside the main decode
   assign is_lxy = (instr[9:8] == 2'b11);
   assign is_la = (instr[9:4] == 6'h07);
   assign is_add_imm = (instr[9:4] == 6'h06);
   assign chain_skip = (is_lxy & prev_lxy_r) | (is_la & prev_la_r);

   // Shared adder operand selection
   assign add_b = is_add_imm ? imm : mem;
   assign add_ci = (instr == `ENC_ADD_MEM_CARRY) & carry_flag_r;

   nibble_add u_add
   (
      .op_a(acc_r),
      .op_b(add_b),
      .cin(add_ci),
      .sum(add_sum),
      .cout(add_co)
   );

   // Next-state and datapath decode
   always @*
   begin
      st_nxt = st_r;
      prev_lxy_nxt = prev_lxy_r;
      prev_la_nxt = prev_la_r;
      sea_pend_nxt = sea_pend_r;
      sea_void_nxt = sea_void_r;
      instr_ready_nxt = instr_ready_r;
      acc_nxt = acc_r;
      b_nxt = b_r;
      e_nxt = e_r;
      d_nxt = d_r;
      x_nxt = x_r;
      y_nxt = y_r;
      z_nxt = z_r;
      carry_nxt = carry_flag_r;
      skip_nxt = skip_r;
      ram_we_nxt = 1'b0;
      ram_waddr_nxt = ram_waddr_r;
      ram_wdata_nxt = ram_wdata_r;
      rom_addr_nxt = rom_addr_r;
      push_nxt = 1'b0;
      pop_nxt = 1'b0;
      case (st_r)
         ST_IDLE:
         begin
            if (take)
            begin
               if (sea_pend_r)
               begin
                  // Second word of the compare carries the immediate
                  sea_pend_nxt = 1'b0;
                  sea_void_nxt = 1'b0;
                  prev_lxy_nxt = 1'b0;
                  prev_la_nxt = 1'b0;
                  skip_nxt = ~sea_void_r & (acc_r == imm);
               end
               else if (skip_r | chain_skip)
               begin
                  // Suppressed word; a suppressed compare drops its second word too
                  skip_nxt = 1'b0;
                  prev_lxy_nxt = is_lxy;
                  prev_la_nxt = is_la;
                  if (instr == `ENC_SKIP_EQ_IMM)
                  begin
                     sea_pend_nxt = 1'b1;
                     sea_void_nxt = 1'b1;
                  end
               end
               else
               begin
                  skip_nxt = 1'b0;
                  prev_lxy_nxt = is_lxy;
                  prev_la_nxt = is_la;
                  casez (instr)
                     `ENC_COPY_B_TO_ACC: acc_nxt = b_r;
                     `ENC_COPY_ACC_TO_B: b_nxt = acc_r;
                     `ENC_COPY_Y_TO_ACC: acc_nxt = y_r;
                     `ENC_COPY_ACC_TO_Y: y_nxt = acc_r;
                     `ENC_READ_X_REG: acc_nxt = x_r;
                     `ENC_LOAD_E_PAIR: e_nxt = {b_r, acc_r};
                     `ENC_READ_E_PAIR: {b_nxt, acc_nxt} = e_r;
                     `ENC_LOAD_PAGE_REG: d_nxt = acc_r[2:0];
                     `ENC_READ_PAGE_REG: acc_nxt = {1'b0, d_r};
                     `ENC_READ_Z_REG: acc_nxt = {2'b00, z_r};
                     `ENC_READ_STACK_PTR: acc_nxt = {1'b0, stack_ptr};
                     `ENC_LOAD_X_Y_IMM:
                     begin
                        x_nxt = instr[`LXY_X_HI:`LXY_X_LO];
                        y_nxt = imm;
                     end
                     `ENC_LOAD_Z_IMM: z_nxt = instr[1:0];
                     `ENC_INC_Y:
                     begin
                        y_nxt = y_up;
                        skip_nxt = (y_up == `Y_WRAP_UP);
                     end
                     `ENC_DEC_Y:
                     begin
                        y_nxt = y_dn;
                        skip_nxt = (y_dn == `Y_WRAP_DN);
                     end
                     `ENC_LOAD_ACC_FROM_MEM:
                     begin
                        acc_nxt = mem;
                        x_nxt = x_r ^ imm;
                     end
                     `ENC_SWAP_ACC_MEM:
                     begin
                        acc_nxt = mem;
                        ram_we_nxt = 1'b1;
                        ram_waddr_nxt = ptr_now;
                        ram_wdata_nxt = acc_r;
                        x_nxt = x_r ^ imm;
                     end
                     `ENC_SWAP_MEM_DEC_Y:
                     begin
                        acc_nxt = mem;
                        ram_we_nxt = 1'b1;
                        ram_waddr_nxt = ptr_now;
                        ram_wdata_nxt = acc_r;
                        x_nxt = x_r ^ imm;
                        y_nxt = y_dn;
                        skip_nxt = (y_dn == `Y_WRAP_DN);
                     end
                     `ENC_SWAP_MEM_INC_Y:
                     begin
                        acc_nxt = mem;
                        ram_we_nxt = 1'b1;
                        ram_waddr_nxt = ptr_now;
                        ram_wdata_nxt = acc_r;
                        x_nxt = x_r ^ imm;
                        y_nxt = y_up;
                        skip_nxt = (y_up == `Y_WRAP_UP);
                     end
                     `ENC_STORE_ACC_TO_MEM:
                     begin
                        ram_we_nxt = 1'b1;
                        ram_waddr_nxt = ptr_now;
                        ram_wdata_nxt = acc_r;
                        x_nxt = x_r ^ imm;
                     end
                     `ENC_LOAD_ACC_IMM: acc_nxt = imm;
                     `ENC_ROM_LOOKUP_CALL:
                     begin
                        // Push the return point and present the table address
                        push_nxt = 1'b1;
                        rom_addr_nxt = {instr[`PAGE_HI:0], d_r, acc_r};
                        instr_ready_nxt = 1'b0;
                        st_nxt = ST_FETCH;
                     end
                     `ENC_ADD_MEM: acc_nxt = add_sum;
                     `ENC_ADD_MEM_CARRY:
                     begin
                        acc_nxt = add_sum;
                        carry_nxt = add_co;
                     end
                     `ENC_ADD_IMM:
                     begin
                        acc_nxt = add_sum;
                        skip_nxt = ~add_co;
                     end
                     `ENC_AND_MEM: acc_nxt = acc_r & mem;
                     `ENC_OR_MEM: acc_nxt = acc_r | mem;
                     `ENC_SET_CARRY: carry_nxt = 1'b1;
                     `ENC_CLEAR_CARRY: carry_nxt = 1'b0;
                     `ENC_SKIP_CARRY_ZERO: skip_nxt = ~carry_flag_r;
                     `ENC_INVERT_ACC: acc_nxt = ~acc_r;
                     `ENC_ROTATE_RIGHT_CARRY:
                     begin
                        acc_nxt = {carry_flag_r, acc_r[3:1]};
                        carry_nxt = acc_r[0];
                     end
                     `ENC_SET_MEM_BIT:
                     begin
                        ram_we_nxt = 1'b1;
                        ram_waddr_nxt = ptr_now;
                        ram_wdata_nxt = mem | bit_mask(instr[`BIT_SEL_HI:0]);
                     end
                     `ENC_CLEAR_MEM_BIT:
                     begin
                        ram_we_nxt = 1'b1;
                        ram_waddr_nxt = ptr_now;
                        ram_wdata_nxt = mem & ~bit_mask(instr[`BIT_SEL_HI:0]);
                     end
                     `ENC_SKIP_BIT_ZERO:
                        skip_nxt = ((mem & bit_mask(instr[`BIT_SEL_HI:0])) == 4'h0);
                     `ENC_SKIP_EQ_MEM: skip_nxt = (acc_r == mem);
                     `ENC_SKIP_EQ_IMM: sea_pend_nxt = 1'b1;
                     default: skip_nxt = 1'b0;
                  endcase
               end
            end
         end
         // Table word becomes valid one cycle after the address
         ST_FETCH: st_nxt = ST_LOAD;
         ST_LOAD:
         begin
            // Take the table word and restore the return point
            b_nxt = rom_rdata[7:4];
            acc_nxt = rom_rdata[3:0];
            pop_nxt = 1'b1;
            instr_ready_nxt = 1'b1;
            st_nxt = ST_IDLE;
         end
         default:
         begin
            st_nxt = ST_IDLE;
            instr_ready_nxt = 1'b1;
         end
      endcase
   end

   // State registers with synchronous reset
   always @(posedge clk)
   begin
      if (srst)
      begin
         st_r <= ST_IDLE;
         prev_lxy_r <= 1'b0;
         prev_la_r <= 1'b0;
         sea_pend_r <= 1'b0;
         sea_void_r <= 1'b0;
         instr_ready_r <= 1'b1;
         acc_r <= `NIB_RST;
         b_r <= `NIB_RST;
         e_r <= {`NIB_RST, `NIB_RST};
         d_r <= 3'h0;
         x_r <= `NIB_RST;
         y_r <= `NIB_RST;
         z_r <= 2'h0;
         carry_flag_r <= 1'b0;
         skip_r <= 1'b0;
         ram_we_r <= 1'b0;
         ram_waddr_r <= 10'h000;
         ram_wdata_r <= `NIB_RST;
         rom_addr_r <= 13'h0000;
         stack_push_r <= 1'b0;
         stack_pop_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         prev_lxy_r <= prev_lxy_nxt;
         prev_la_r <= prev_la_nxt;
         sea_pend_r <= sea_pend_nxt;
         sea_void_r <= sea_void_nxt;
         instr_ready_r <= instr_ready_nxt;
         acc_r <= acc_nxt;
         b_r <= b_nxt;
         e_r <= e_nxt;
         d_r <= d_nxt;
         x_r <= x_nxt;
         y_r <= y_nxt;
         z_r <= z_nxt;
         carry_flag_r <= carry_nxt;
         skip_r <= skip_nxt;
         ram_we_r <= ram_we_nxt;
         ram_waddr_r <= ram_waddr_nxt;
         ram_wdata_r <= ram_wdata_nxt;
         rom_addr_r <= rom_addr_nxt;
         stack_push_r <= push_nxt;
         stack_pop_r <= pop_nxt;
      end
   end

endmodule // nibble_exec

`default_nettype wire

// ---- hdl/nibble_exec_map.vh ----
// Opcode patterns, field positions and reset values of the nibble execute unit
`ifndef NIBBLE_EXEC_MAP_VH
`define NIBBLE_EXEC_MAP_VH

// Register to register moves
`define ENC_COPY_B_TO_ACC 10'h01e
`define ENC_COPY_ACC_TO_B 10'h00e
`define ENC_COPY_Y_TO_ACC 10'h01f
`define ENC_COPY_ACC_TO_Y 10'h00c
`define ENC_LOAD_E_PAIR 10'h01a
`define ENC_READ_E_PAIR 10'h02a
`define ENC_LOAD_PAGE_REG 10'h029
`define ENC_READ_PAGE_REG 10'h051
`define ENC_READ_Z_REG 10'h053
`define ENC_READ_X_REG 10'h052
`define ENC_READ_STACK_PTR 10'h050

// RAM pointer handling
`define ENC_LOAD_X_Y_IMM 10'h3??
`define ENC_LOAD_Z_IMM 10'b00010010??
`define ENC_INC_Y 10'h013
`define ENC_DEC_Y 10'h017

// Transfers between RAM and the accumulator
`define ENC_LOAD_ACC_FROM_MEM 10'h2c?
`define ENC_SWAP_ACC_MEM 10'h2d?
`define ENC_SWAP_MEM_DEC_Y 10'h2f?
`define ENC_SWAP_MEM_INC_Y 10'h2e?
`define ENC_STORE_ACC_TO_MEM 10'h2b?

// Arithmetic, logic and bit operations
`define ENC_LOAD_ACC_IMM 10'h07?
`define ENC_ROM_LOOKUP_CALL 10'b0010??????
`define ENC_ADD_MEM 10'h00a
`define ENC_ADD_MEM_CARRY 10'h00b
`define ENC_ADD_IMM 10'h06?
`define ENC_AND_MEM 10'h018
`define ENC_OR_MEM 10'h019
`define ENC_SET_CARRY 10'h007
`define ENC_CLEAR_CARRY 10'h006
`define ENC_SKIP_CARRY_ZERO 10'h02f
`define ENC_INVERT_ACC 10'h01c
`define ENC_ROTATE_RIGHT_CARRY 10'h01d
`define ENC_SET_MEM_BIT 10'b00010111??
`define ENC_CLEAR_MEM_BIT 10'b00010011??
`define ENC_SKIP_BIT_ZERO 10'b00001000??
`define ENC_SKIP_EQ_MEM 10'h026
`define ENC_SKIP_EQ_IMM 10'h025

// Field positions
`define IMM_HI 3
`define IMM_LO 0
`define LXY_X_HI 7
`define LXY_X_LO 4
`define PAGE_HI 5
`define BIT_SEL_HI 1

// Reset values and wrap points
`define NIB_RST 4'h0
`define Y_WRAP_UP 4'h0
`define Y_WRAP_DN 4'hf

`endif
